// ===== ms_regs.svh
`ifndef MS_REGS_SVH
`define MS_REGS_SVH

// Control word fields
`define MS_MODE_HI 5
`define MS_MODE_LO 2
`define MS_PWR_HI 7
`define MS_PWR_LO 6
`define MS_CTRL_RST 8'h00

// Mode codes
`define MS_M_CONT 4'h0
`define MS_M_SINGLE 4'h1
`define MS_M_STBY 4'h2
`define MS_M_PDOWN 4'h3
`define MS_M_IDLE 4'h4
`define MS_M_INTZS 4'h5
`define MS_M_INTFS 4'h6
`define MS_M_SYSZS 4'h7
`define MS_M_SYSFS 4'h8
`define MS_M_LAST 4'h8

// Power settings
`define MS_PWR_LOW 2'h0
`define MS_PWR_FULL 2'h2

// Coefficient and data defaults
`define MS_OFFS_RST 24'h800000
`define MS_GAIN_RST 24'h500000
`define MS_DATA_RST 24'h000000

// Timing: one filter settling period in clk_sys cycles
`define MS_SETTLE_CYC 16'h0040
`define MS_FS_PERIODS 3'h4
`define MS_ONE_PERIOD 3'h1

// Standby keep-alive enable positions
`define MS_AUX_W 4
`define MS_AUX_ALL 4'hF
`define MS_AUX_OFF 4'h0

`endif

// ===== ms_pkg.sv
`include "ms_regs.svh"

package ms_pkg;

   typedef enum logic [2:0] {
      MS_ST_PDOWN,
      MS_ST_STBY,
      MS_ST_IDLE,
      MS_ST_CONV,
      MS_ST_CAL
   } ms_dev_state_t;

   typedef enum logic [2:0] {
      MS_HS_IDLE,
      MS_HS_OFFS,
      MS_HS_CTRL,
      MS_HS_WAIT,
      MS_HS_READ,
      MS_HS_REPLAY
   } ms_host_state_t;

   typedef struct packed {
      ms_dev_state_t st;
      logic [7:0] ctrl;
      logic [15:0] cnt;
      logic [2:0] per;
      logic [23:0] data;
      logic rdy_n;
      logic [3:0][23:0] offs;
      logic [3:0][23:0] gain;
      logic [23:0] rb_offs;
      logic [23:0] rb_gain;
      logic diag_run;
      logic mod_rst;
      logic clk_on;
      logic regulator_on;
      logic short_in;
      logic fs_ref_in;
      logic [3:0] aux_en;
      logic [1:0] ch_sync1;
      logic [1:0] ch_sync2;
   } ms_dev_t;

   typedef struct packed {
      ms_host_state_t st;
      logic [3:0] mode;
      logic [1:0] chan;
      logic [1:0] pwr;
      logic ctrl_wr;
      logic [7:0] ctrl_wdata;
      logic offs_wr;
      logic [23:0] offs_wdata;
      logic [23:0] offs_shadow;
      logic data_rd;
      logic [3:0] chan_en;
      logic seen_high;
      logic pd;
      logic busy;
      logic done;
      logic refused;
      logic [23:0] result;
      logic sys_zero_apply;
      logic sys_full_apply;
      logic [1:0] gain_last;
      logic cal_due;
   } ms_host_t;

endpackage : ms_pkg

// ===== ms_link_if.sv
`timescale 1ns/1ps

interface ms_link_if;
   // Host to device
   logic ctrl_wr;
   logic [7:0] ctrl_wdata;
   logic offs_wr;
   logic [23:0] offs_wdata;
   logic data_rd;
   logic [3:0] chan_en;
   logic gain_one;
   logic diag_en;
   logic [3:0] keep_en;
   // Device to host
   logic rdy_n;
   logic [23:0] data;
   logic [7:0] ctrl_rd;
   logic [23:0] offs_rd;
   logic [23:0] gain_rd;

   modport dev (
      input ctrl_wr, ctrl_wdata, offs_wr, offs_wdata, data_rd, chan_en, gain_one,
      input diag_en, keep_en,
      output rdy_n, data, ctrl_rd, offs_rd, gain_rd
   );

   modport host (
      output ctrl_wr, ctrl_wdata, offs_wr, offs_wdata, data_rd, chan_en, gain_one,
      output diag_en, keep_en,
      input rdy_n, data, ctrl_rd, offs_rd, gain_rd
   );
endinterface : ms_link_if

// ===== ms_device.sv
// Function
// - Mode field bits 5:2, default continuous
// - Continuous: convert repeatedly, update, ready low
// - Single: one conversion, full settling time
// - Single: store, ready low, then standby
// - Single result holds until read/new conversion
// - Standby keeps registers, aux blocks selectable
// - Standby keeps running diagnostics, ignores new enables
// - Clocked diagnostics start only in continuous/single conversion/idle/calibration
// - Power-down loses registers; host reprograms after
// - Idle holds filter/modulator reset, clocks run
// - Calibration: ready high, low, then idle
// - Internal zero: short input, one period, offset
// - Internal full: four periods gain>1, gain
// - Host never internal full-scale at gain one
// - Host uses mid/low power for internal full-scale
// - Host resets offset before internal full-scale
// - System zero: host applies zero, offset stored
// - System full: host applies full, gain stored
// - Host enables exactly one calibration channel
// - Host raises cal_due after gain change until a system calibration
`timescale 1ns/1ps
`include "ms_regs.svh"

module ms_device (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Link to host
   ms_link_if.dev link,
   // Converter front end
   input wire logic [23:0] sample,
   // Analog control
   output logic mod_rst,
   output logic clk_on,
   output logic regulator_on,
   output logic short_in,
   output logic fs_ref_in,
   output logic [3:0] aux_en,
   output logic diag_run
);

   ms_pkg::ms_dev_t q;
   ms_pkg::ms_dev_t d;
   logic [3:0] mode_q;

   // One-hot channel enable to index; lowest set bit wins
   function automatic logic [1:0] ms_chan_idx(input logic [3:0] en);
      logic [1:0] idx;
      idx = 2'h0;
      for (int i = 3; i >= 0; i--) begin
         if (en[i]) begin
            idx = 2'(i);
         end
      end
      return idx;
   endfunction : ms_chan_idx

   function automatic logic [7:0] ms_set_mode(input logic [7:0] c, input logic [3:0] m);
      logic [7:0] r;
      r = c;
      r[`MS_MODE_HI:`MS_MODE_LO] = m;
      return r;
   endfunction : ms_set_mode

   assign mode_q = q.ctrl[`MS_MODE_HI:`MS_MODE_LO];

   always_comb begin
      logic [3:0] m;
      logic [1:0] ch;
      logic done;
      m = 4'h0;
      ch = 2'h0;
      done = 1'b0;
      d = q;
      // Channel select is a level from another party's logic; it is stable during a
      // calibration, but latched here so a change mid-cycle cannot split a store
      d.ch_sync1 = ms_chan_idx(link.chan_en);
      d.ch_sync2 = q.ch_sync1;
      ch = q.ch_sync2;

      // Reading the result releases the ready flag
      if (link.data_rd && q.st != ms_pkg::MS_ST_PDOWN) begin
         d.rdy_n = 1'b1;
      end

      if (link.offs_wr && q.st != ms_pkg::MS_ST_PDOWN) begin
         d.offs[ms_chan_idx(link.chan_en)] = link.offs_wdata;
      end

      // Settling count runs only while converting or calibrating
      if (q.st == ms_pkg::MS_ST_CONV || q.st == ms_pkg::MS_ST_CAL) begin
         if (q.cnt == `MS_SETTLE_CYC - 16'h0001) begin
            d.cnt = 16'h0000;
            if (q.per > `MS_ONE_PERIOD) begin
               d.per = q.per - `MS_ONE_PERIOD;
            end else begin
               done = 1'b1;
            end
         end else begin
            d.cnt = q.cnt + 16'h0001;
         end
      end

      if (done) begin
         unique case (q.st)
            ms_pkg::MS_ST_CONV: begin
               d.data = sample;
               d.rdy_n = 1'b0;
               d.per = `MS_ONE_PERIOD;
               if (mode_q == `MS_M_SINGLE) begin
                  d.st = ms_pkg::MS_ST_STBY;
                  d.ctrl = ms_set_mode(q.ctrl, `MS_M_STBY);
               end
            end
            ms_pkg::MS_ST_CAL: begin
               if (mode_q == `MS_M_INTZS || mode_q == `MS_M_SYSZS) begin
                  d.offs[ch] = sample;
               end else begin
                  d.gain[ch] = sample;
               end
               d.rdy_n = 1'b0;
               d.st = ms_pkg::MS_ST_IDLE;
               d.ctrl = ms_set_mode(q.ctrl, `MS_M_IDLE);
            end
            default: begin
               d.st = q.st;
            end
         endcase
      end

      // A new control write overrides any conversion in flight
      if (link.ctrl_wr) begin
         m = link.ctrl_wdata[`MS_MODE_HI:`MS_MODE_LO];
         d.ctrl = link.ctrl_wdata;
         d.cnt = 16'h0000;
         d.per = `MS_ONE_PERIOD;
         unique case (m)
            `MS_M_CONT: begin
               d.st = ms_pkg::MS_ST_CONV;
            end
            `MS_M_SINGLE: begin
               d.st = ms_pkg::MS_ST_CONV;
               d.rdy_n = 1'b1;
            end
            `MS_M_STBY: begin
               d.st = ms_pkg::MS_ST_STBY;
            end
            `MS_M_PDOWN: begin
               d.st = ms_pkg::MS_ST_PDOWN;
            end
            `MS_M_INTZS, `MS_M_SYSZS, `MS_M_SYSFS: begin
               d.st = ms_pkg::MS_ST_CAL;
               d.rdy_n = 1'b1;
            end
            `MS_M_INTFS: begin
               d.st = ms_pkg::MS_ST_CAL;
               d.rdy_n = 1'b1;
               // Gain one is unsupported; a single period is taken then
               d.per = link.gain_one ? `MS_ONE_PERIOD : `MS_FS_PERIODS;
            end
            default: begin
               // Idle, and reserved codes parked safely in idle
               d.st = ms_pkg::MS_ST_IDLE;
               d.ctrl = ms_set_mode(link.ctrl_wdata, `MS_M_IDLE);
            end
         endcase
      end

      // Power-down wipes everything except the wake-up write
      if (d.st == ms_pkg::MS_ST_PDOWN) begin
         d.ctrl = ms_set_mode(`MS_CTRL_RST, `MS_M_PDOWN);
         d.cnt = 16'h0000;
         d.per = `MS_ONE_PERIOD;
         d.data = `MS_DATA_RST;
         d.rdy_n = 1'b1;
         for (int i = 0; i < 4; i++) begin
            d.offs[i] = `MS_OFFS_RST;
            d.gain[i] = `MS_GAIN_RST;
         end
      end

      // Clocked diagnostics start only where the master clock runs
      if (!link.diag_en) begin
         d.diag_run = 1'b0;
      end else if (d.st == ms_pkg::MS_ST_CONV || d.st == ms_pkg::MS_ST_IDLE ||
                   d.st == ms_pkg::MS_ST_CAL) begin
         d.diag_run = 1'b1;
      end else if (d.st == ms_pkg::MS_ST_PDOWN) begin
         d.diag_run = 1'b0;
      end else begin
         d.diag_run = q.diag_run;
      end

      d.mod_rst = !(d.st == ms_pkg::MS_ST_CONV || d.st == ms_pkg::MS_ST_CAL);
      d.regulator_on = d.st != ms_pkg::MS_ST_PDOWN;
      unique case (d.st)
         ms_pkg::MS_ST_PDOWN: begin
            d.aux_en = `MS_AUX_OFF;
         end
         ms_pkg::MS_ST_STBY: begin
            d.aux_en = link.keep_en;
         end
         default: begin
            d.aux_en = `MS_AUX_ALL;
         end
      endcase
      d.clk_on = d.aux_en[1] || d.st == ms_pkg::MS_ST_IDLE;
      d.short_in = d.st == ms_pkg::MS_ST_CAL &&
                   d.ctrl[`MS_MODE_HI:`MS_MODE_LO] == `MS_M_INTZS;
      d.fs_ref_in = d.st == ms_pkg::MS_ST_CAL &&
                    d.ctrl[`MS_MODE_HI:`MS_MODE_LO] == `MS_M_INTFS;
      d.rb_offs = d.offs[ms_chan_idx(link.chan_en)];
      d.rb_gain = d.gain[ms_chan_idx(link.chan_en)];
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         q.st <= ms_pkg::MS_ST_CONV;
         q.ctrl <= `MS_CTRL_RST;
         q.cnt <= 16'h0000;
         q.per <= `MS_ONE_PERIOD;
         q.data <= `MS_DATA_RST;
         q.rdy_n <= 1'b1;
         for (int i = 0; i < 4; i++) begin
            q.offs[i] <= `MS_OFFS_RST;
            q.gain[i] <= `MS_GAIN_RST;
         end
         q.rb_offs <= `MS_OFFS_RST;
         q.rb_gain <= `MS_GAIN_RST;
         q.diag_run <= 1'b0;
         q.mod_rst <= 1'b0;
         q.clk_on <= 1'b1;
         q.regulator_on <= 1'b1;
         q.short_in <= 1'b0;
         q.fs_ref_in <= 1'b0;
         q.aux_en <= `MS_AUX_ALL;
         q.ch_sync1 <= 2'h0;
         q.ch_sync2 <= 2'h0;
      end else begin
         q <= d;
      end
   end

   assign link.rdy_n = q.rdy_n;
   assign link.data = q.data;
   assign link.ctrl_rd = q.ctrl;
   assign link.offs_rd = q.rb_offs;
   assign link.gain_rd = q.rb_gain;
   assign mod_rst = q.mod_rst;
   assign clk_on = q.clk_on;
   assign regulator_on = q.regulator_on;
   assign short_in = q.short_in;
   assign fs_ref_in = q.fs_ref_in;
   assign aux_en = q.aux_en;
   assign diag_run = q.diag_run;

endmodule : ms_device

// ===== ms_host.sv
`timescale 1ns/1ps
`include "ms_regs.svh"

module ms_host (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Link to device
   ms_link_if.host link,
   // User command
   input wire logic cmd_valid,
   input wire logic [3:0] cmd_mode,
   input wire logic [1:0] cmd_chan,
   input wire logic [1:0] cmd_pwr,
   input wire logic [1:0] cmd_gain,
   input wire logic [23:0] cmd_offs,
   input wire logic cmd_offs_wr,
   input wire logic user_diag_en,
   input wire logic [3:0] user_keep_en,
   // User status
   output logic busy,
   output logic done,
   output logic refused,
   output logic [23:0] result,
   output logic sys_zero_apply,
   output logic sys_full_apply,
   output logic cal_due
);

   ms_pkg::ms_host_t q;
   ms_pkg::ms_host_t d;

   always_comb begin
      d = q;
      d.ctrl_wr = 1'b0;
      d.offs_wr = 1'b0;
      d.data_rd = 1'b0;
      d.done = 1'b0;
      d.refused = 1'b0;
      d.gain_last = cmd_gain;
      if (cmd_gain != q.gain_last) begin
         d.cal_due = 1'b1;
      end
      unique case (q.st)
         ms_pkg::MS_HS_IDLE: begin
            if (cmd_offs_wr && !cmd_valid) begin
               d.offs_wr = 1'b1;
               d.offs_wdata = cmd_offs;
               d.offs_shadow = cmd_offs;
            end else if (cmd_valid) begin
               if (cmd_mode > `MS_M_LAST ||
                   (cmd_mode == `MS_M_INTFS && cmd_gain == 2'h0)) begin
                  d.refused = 1'b1;
               end else begin
                  d.mode = cmd_mode;
                  d.chan = cmd_chan;
                  d.pwr = cmd_mode == `MS_M_INTFS ? `MS_PWR_LOW : cmd_pwr;
                  d.chan_en = 4'h1 << cmd_chan;
                  d.busy = 1'b1;
                  d.seen_high = 1'b0;
                  d.st = cmd_mode == `MS_M_INTFS ? ms_pkg::MS_HS_OFFS :
                         (q.pd ? ms_pkg::MS_HS_REPLAY : ms_pkg::MS_HS_CTRL);
               end
            end
         end
         ms_pkg::MS_HS_REPLAY: begin
            // Offset writes are ignored while powered down, so wake into idle first
            if (q.pd) begin
               d.ctrl_wr = 1'b1;
               d.ctrl_wdata = {q.pwr, `MS_M_IDLE, 2'h0};
               d.pd = 1'b0;
            end else begin
               d.offs_wr = 1'b1;
               d.offs_wdata = q.offs_shadow;
               d.st = ms_pkg::MS_HS_CTRL;
            end
         end
         ms_pkg::MS_HS_OFFS: begin
            d.offs_wr = 1'b1;
            d.offs_wdata = `MS_OFFS_RST;
            d.offs_shadow = `MS_OFFS_RST;
            d.st = ms_pkg::MS_HS_CTRL;
         end
         ms_pkg::MS_HS_CTRL: begin
            d.ctrl_wr = 1'b1;
            d.ctrl_wdata = {q.pwr, q.mode, 2'h0};
            d.pd = q.mode == `MS_M_PDOWN;
            d.sys_zero_apply = q.mode == `MS_M_SYSZS;
            d.sys_full_apply = q.mode == `MS_M_SYSFS;
            if (q.mode == `MS_M_SYSZS || q.mode == `MS_M_SYSFS) begin
               d.cal_due = 1'b0;
            end
            d.st = (q.mode == `MS_M_CONT || q.mode == `MS_M_STBY || q.mode == `MS_M_PDOWN ||
                    q.mode == `MS_M_IDLE) ? ms_pkg::MS_HS_READ : ms_pkg::MS_HS_WAIT;
         end
         ms_pkg::MS_HS_WAIT: begin
            // Ready must first be seen high so a stale low is not taken as done
            if (link.rdy_n) begin
               d.seen_high = 1'b1;
            end else if (q.seen_high) begin
               d.data_rd = q.mode == `MS_M_SINGLE;
               d.result = q.mode == `MS_M_SINGLE ? link.data : link.gain_rd;
               d.sys_zero_apply = 1'b0;
               d.sys_full_apply = 1'b0;
               d.st = ms_pkg::MS_HS_READ;
            end
         end
         ms_pkg::MS_HS_READ: begin
            d.busy = 1'b0;
            d.done = 1'b1;
            d.st = ms_pkg::MS_HS_IDLE;
         end
         default: begin
            d.st = ms_pkg::MS_HS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         q <= '0;
         q.st <= ms_pkg::MS_HS_IDLE;
         q.offs_wdata <= `MS_OFFS_RST;
         q.offs_shadow <= `MS_OFFS_RST;
         q.chan_en <= 4'h1;
         q.pwr <= `MS_PWR_FULL;
      end else begin
         q <= d;
      end
   end

   assign link.ctrl_wr = q.ctrl_wr;
   assign link.ctrl_wdata = q.ctrl_wdata;
   assign link.offs_wr = q.offs_wr;
   assign link.offs_wdata = q.offs_wdata;
   assign link.data_rd = q.data_rd;
   assign link.chan_en = q.chan_en;
   assign link.gain_one = q.gain_last == 2'h0;
   assign link.diag_en = user_diag_en;
   assign link.keep_en = user_keep_en;
   assign busy = q.busy;
   assign done = q.done;
   assign refused = q.refused;
   assign result = q.result;
   assign sys_zero_apply = q.sys_zero_apply;
   assign sys_full_apply = q.sys_full_apply;
   assign cal_due = q.cal_due;

endmodule : ms_host

// ===== ms_link_props.sv
`timescale 1ns/1ps
`include "ms_regs.svh"

module ms_link_props (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Host to device
   input wire logic ctrl_wr,
   input wire logic [7:0] ctrl_wdata,
   input wire logic data_rd,
   input wire logic gain_one,
   // Device to host
   input wire logic rdy_n,
   input wire logic [23:0] data,
   input wire logic [7:0] ctrl_rd,
   input wire logic [23:0] offs_rd,
   input wire logic [23:0] gain_rd
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   wire logic [3:0] wr_mode = ctrl_wdata[`MS_MODE_HI:`MS_MODE_LO];
   wire logic [3:0] rd_mode = ctrl_rd[`MS_MODE_HI:`MS_MODE_LO];
   // Extra guard: no conversion is due after a power-down write
   logic pd_q;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         pd_q <= 1'b0;
      end else if (ctrl_wr) begin
         pd_q <= (wr_mode == `MS_M_PDOWN);
      end
   end

   mode_reset_a: assert property ($past(reset) |-> ctrl_rd == `MS_CTRL_RST)
      else $error("control word not default after reset");
   mode_echo_a: assert property (
      ctrl_wr && wr_mode <= `MS_M_LAST && wr_mode != `MS_M_PDOWN |=> ctrl_rd == $past(ctrl_wdata))
      else $error("control word not taken");
   cal_start_a: assert property (
      ctrl_wr && wr_mode inside {[`MS_M_INTZS:`MS_M_SYSFS]} |=> rdy_n)
      else $error("ready not raised at calibration start");
   one_period_a: assert property (
      ctrl_wr && wr_mode inside {`MS_M_SINGLE, `MS_M_INTZS, `MS_M_SYSZS, `MS_M_SYSFS}
      |=> rdy_n [*8] ##[48:60] $fell(rdy_n))
      else $error("single period operation mistimed");
   four_period_a: assert property (
      ctrl_wr && wr_mode == `MS_M_INTFS && !gain_one |=> rdy_n [*8] ##[240:252] $fell(rdy_n))
      else $error("full-scale calibration mistimed");
   done_mode_a: assert property (
      $fell(rdy_n) |-> rd_mode inside {`MS_M_CONT, `MS_M_STBY, `MS_M_IDLE})
      else $error("wrong mode after completion");
   result_hold_a: assert property (
      !rdy_n && rd_mode == `MS_M_STBY && !data_rd && !ctrl_wr |=> !rdy_n && $stable(data))
      else $error("standby result not held");
   read_release_a: assert property (
      data_rd && rd_mode == `MS_M_STBY && !ctrl_wr |=> rdy_n)
      else $error("read did not release ready");
   cont_rate_a: assert property (
      rd_mode == `MS_M_CONT && !pd_q && !ctrl_wr |-> ##[0:70] (!rdy_n || ctrl_wr))
      else $error("continuous conversion stalled");
   pdown_clear_a: assert property (
      ctrl_wr && wr_mode == `MS_M_PDOWN |=> ##1 (data == `MS_DATA_RST
      && offs_rd == `MS_OFFS_RST && gain_rd == `MS_GAIN_RST))
      else $error("power-down kept register contents");
endmodule : ms_link_props

// ===== adc_operating_mode_sequencer_tb_top.sv
`timescale 1ns/1ps
`include "ms_regs.svh"

module adc_operating_mode_sequencer_tb_top;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic cmd_valid = 1'b0;
   logic [3:0] cmd_mode = 4'h0;
   logic [1:0] cmd_chan = 2'h0;
   logic [1:0] cmd_gain = 2'h1;
   logic user_diag_en = 1'b0;
   logic [3:0] user_keep_en = 4'hF;
   logic [23:0] sample = 24'h000000;
   logic [23:0] cmd_offs = 24'h000000;
   logic cmd_offs_wr = 1'b0;
   logic mod_rst, clk_on, regulator_on, short_in, fs_ref_in, diag_run;
   logic [3:0] aux_en;
   logic busy, done, refused, sys_zero_apply, sys_full_apply, cal_due;
   logic [23:0] result;
   logic [3:0] seen = 4'h0;
   logic [25:0] exp_q[$];
   logic [25:0] e;
   int fail_count = 0;
   int num_checks = 0;

   always #4 clk_sys = ~clk_sys;

   ms_link_if ms_link_if_inst ();
   wire logic [3:0] link_mode = ms_link_if_inst.ctrl_rd[`MS_MODE_HI:`MS_MODE_LO];

   ms_device ms_device_inst (.clk_sys(clk_sys), .reset(reset), .link(ms_link_if_inst),
      .sample(sample), .mod_rst(mod_rst), .clk_on(clk_on), .regulator_on(regulator_on),
      .short_in(short_in), .fs_ref_in(fs_ref_in), .aux_en(aux_en), .diag_run(diag_run));
   ms_host ms_host_inst (.clk_sys(clk_sys), .reset(reset), .link(ms_link_if_inst),
      .cmd_valid(cmd_valid), .cmd_mode(cmd_mode), .cmd_chan(cmd_chan), .cmd_pwr(2'h2),
      .cmd_gain(cmd_gain), .cmd_offs(cmd_offs), .cmd_offs_wr(cmd_offs_wr),
      .user_diag_en(user_diag_en), .user_keep_en(user_keep_en), .busy(busy), .done(done),
      .refused(refused), .result(result), .sys_zero_apply(sys_zero_apply),
      .sys_full_apply(sys_full_apply), .cal_due(cal_due));
   ms_link_props ms_link_props_inst (.clk_sys(clk_sys), .reset(reset),
      .ctrl_wr(ms_link_if_inst.ctrl_wr), .ctrl_wdata(ms_link_if_inst.ctrl_wdata),
      .data_rd(ms_link_if_inst.data_rd), .gain_one(ms_link_if_inst.gain_one),
      .rdy_n(ms_link_if_inst.rdy_n), .data(ms_link_if_inst.data),
      .ctrl_rd(ms_link_if_inst.ctrl_rd), .offs_rd(ms_link_if_inst.offs_rd),
      .gain_rd(ms_link_if_inst.gain_rd));

   task automatic check(input string what, input logic [23:0] seen_v, input logic [23:0] exp_v);
      num_checks++;
      if (seen_v !== exp_v) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp_v, seen_v);
      end
   endtask : check

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_of_test

   task automatic settle;
      repeat (4) @(posedge clk_sys);
      #1;
   endtask : settle

   // Note entry: care bit, refusal bit, expected result
   task automatic run(input logic [3:0] m, input logic [1:0] ch, input logic [25:0] ex);
      int n;
      exp_q.push_back(ex);
      cmd_mode = m;
      cmd_chan = ch;
      cmd_valid = 1'b1;
      @(posedge clk_sys);
      #1;
      cmd_valid = 1'b0;
      n = 0;
      while ((exp_q.size() != 0 || busy !== 1'b0) && n < 3000) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      if (exp_q.size() != 0 || busy !== 1'b0) begin
         fail_count++;
         end_of_test();
      end
   endtask : run

   // Apply strobes are sticky so short pulses inside a long wait are not missed
   always @(posedge clk_sys) begin
      seen <= (cmd_valid ? 4'h0 : seen) | {short_in, fs_ref_in, sys_zero_apply, sys_full_apply};
      if (done === 1'b1 || refused === 1'b1) begin
         if (exp_q.size() == 0) begin
            check("unexpected", 24'h1, 24'h0);
         end else begin
            e = exp_q.pop_front();
            check("refused", {23'h0, refused}, {23'h0, e[24]});
            if (e[25]) check("result", result, e[23:0]);
         end
      end
   end

   initial begin
      void'($urandom(32'hC95452C3));
      repeat (5) @(posedge clk_sys);
      #1;
      reset = 1'b0;
      repeat (150) @(posedge clk_sys);
      #1;
      for (int i = 0; i < 2; i++) begin
         sample = 24'($urandom());
         run(`MS_M_SINGLE, 2'h0, {2'b10, sample});
         check("mode", {20'h0, link_mode}, {20'h0, `MS_M_STBY});
      end
      for (int m = 9; m < 16; m++) run(4'(m), 2'h0, {2'b01, 24'h0});
      cmd_gain = 2'h0;
      run(`MS_M_INTFS, 2'h1, {2'b01, 24'h0});
      cmd_gain = 2'h1;
      for (int m = 5; m < 9; m++) begin
         run(4'(m), 2'(m - 5), {2'b10, (m % 2 != 0) ? `MS_GAIN_RST : sample});
         check("due", {23'h0, cal_due}, {23'h0, m < 7});
         check("power", {22'h0, ms_link_if_inst.ctrl_rd[`MS_PWR_HI:`MS_PWR_LO]},
            {22'h0, (m == 6) ? `MS_PWR_LOW : `MS_PWR_FULL});
         check("apply", {20'h0, seen}, {20'h0, 4'h8 >> (m - 5)});
         check("mode", {20'h0, link_mode}, {20'h0, `MS_M_IDLE});
         check("idle", {22'h0, mod_rst, clk_on}, 24'h3);
      end
      user_keep_en = 4'($urandom());
      run(`MS_M_STBY, 2'h0, 26'h0);
      check("keep", {20'h0, aux_en}, {20'h0, user_keep_en});
      user_diag_en = 1'b1;
      settle();
      check("diag", {23'h0, diag_run}, 24'h0);
      run(`MS_M_IDLE, 2'h0, 26'h0);
      check("diag", {23'h0, diag_run}, 24'h1);
      run(`MS_M_STBY, 2'h0, 26'h0);
      check("diag", {23'h0, diag_run}, 24'h1);
      user_diag_en = 1'b0;
      settle();
      check("diag", {23'h0, diag_run}, 24'h0);
      cmd_offs = 24'($urandom());
      cmd_offs_wr = 1'b1;
      @(posedge clk_sys);
      #1;
      cmd_offs_wr = 1'b0;
      run(`MS_M_PDOWN, 2'h0, 26'h0);
      check("off", {18'h0, aux_en, clk_on, regulator_on}, 24'h0);
      sample = 24'($urandom());
      run(`MS_M_SINGLE, 2'h0, {2'b10, sample});
      check("replay", ms_link_if_inst.offs_rd, cmd_offs);
      run(`MS_M_CONT, 2'h0, 26'h0);
      repeat (150) @(posedge clk_sys);
      #1;
      check("run", {23'h0, mod_rst}, 24'h0);
      end_of_test();
   end
endmodule : adc_operating_mode_sequencer_tb_top
